// file: rtl/hwm_top.sv
// hwm_top: two-wire slave, control register, value memory and monitoring loop
// What this block does
// - slave only; bus pins are sampled, monitoring runs on its own timing.
// - write is address byte, pointer byte, then one data byte at pointer.
// - read with preset pointer is address byte then one returned data byte.
// - answer address 0101 followed by the three address pin levels.
// - power-up sets control, status, mask, divisor, temperature config registers.
// - control bit 7 repeats power-up register init and clears itself.
// - software init leaves value memory results and limits untouched.
// - external reset held low at least 50 ns returns power-up state.
// - after power-up converter stopped, interrupt clear set, both outputs released.
// - control bit 0 low stops loop; registers stay reachable; high starts it.
// - control bit 1 high enables driving the interrupt output.
// - control bit 2 picks open source or open drain interrupt output.
// - control bit 3 clears interrupt output, halts monitoring, keeps status.
// - control bit 4 makes a 10 ms reset pulse when pin in reset mode and bit 3 is low.
// - control bit 5 drives the chassis intrusion pin to reset the latch.
// - control bit 6 sets the general purpose output level.
// - start with bit 3 low, bit 0 high; pass about 1 s, 2 s in 12-bit.
// - pass order temperature, analog channels 0 to 6, fan one, fan two.
// - reads give last result; reading a result restarts the conversion.
// - analog channels yield 8-bit unsigned codes of 10 mV per count.
// - a value beyond its limit sets its interrupt status flag.
// - value memory occupies pointer window 20h to 3Fh.
`timescale 1ns/1ns
`default_nettype none
module hwm_top
#(
    parameter int RST_PULSE_CYC = hwm_pkg::RST_PULSE_DEF,
    parameter int ITEM_CYC = hwm_pkg::ITEM_CYC_DEF
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // two-wire bus, address pins and external reset
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    input wire logic [2:0] BUS_ADDRESS_PINS,
    input wire logic EXTERNAL_RESET_INPUT_N,
    // hardware outputs and chassis intrusion sense input
    output logic IRQ_O,
    output logic IRQ_OE,
    output logic RESET_OR_OVERTEMP_OUTPUT_O,
    output logic RESET_OR_OVERTEMP_OUTPUT_OE,
    input wire logic CHASSIS_INTRUSION_PIN_I,
    output logic CHASSIS_INTRUSION_PIN_O,
    output logic CHASSIS_INTRUSION_PIN_OE,
    output logic GENERAL_PURPOSE_OUTPUT,
    // converter front end: item select, latch strobe, result
    output logic [3:0] MEAS_SEL,
    output logic MEAS_STROBE,
    input wire logic [7:0] MEAS_DATA
);
    import hwm_pkg::*;

    hwm_state_t q;
    hwm_state_t n;
    logic scl, sda, rise, fall, start, stop, byte_done, run;
    logic [2:0] ch;
    logic [4:0] idx;
    logic [7:0] rd;
    logic [24:0] dlim;
    logic rdres;

    assign scl = q.scl_s[1];
    assign sda = q.sda_s[1];
    assign rise = scl & ~q.scl_p;
    assign fall = ~scl & q.scl_p;
    assign start = scl & q.scl_p & q.sda_p & ~sda;
    assign stop = scl & q.scl_p & ~q.sda_p & sda;
    assign byte_done = fall && q.bcnt == BYTE_BITS;
    assign run = q.r.cfg[C_START] & ~q.r.cfg[C_INTCLR];
    assign ch = 3'(q.item - 4'd1);

    always_comb begin
        n = q;
        rdres = 1'b0;
        idx = 5'(q.item);
        rd = 8'h00;
        dlim = q.r.oscfg[O_RES12] ? 25'(2 * ITEM_CYC - 1) : 25'(ITEM_CYC - 1);
        n.strobe = 1'b0;
        n.scl_s = {q.scl_s[0], SCL_I};
        n.sda_s = {q.sda_s[0], SDA_I};
        n.intr_s = {q.intr_s[0], CHASSIS_INTRUSION_PIN_I};
        n.rstn_s = {q.rstn_s[0], EXTERNAL_RESET_INPUT_N};
        n.adr_s0 = BUS_ADDRESS_PINS;
        n.adr_s1 = q.adr_s0;
        n.scl_p = scl;
        n.sda_p = sda;
        if (q.ptr[7:5] == RAM_SEL) begin
            rd = q.ram[q.ptr[4:0]];
        end else begin
            case (q.ptr)
                A_CFG: rd = q.r.cfg;
                A_IST1: rd = q.r.ist1;
                A_IST2: rd = q.r.ist2;
                A_IMK1: rd = q.r.imk1;
                A_IMK2: rd = q.r.imk2;
                A_FDIV: rd = q.r.fdiv;
                A_OSCFG: rd = q.r.oscfg;
                default: rd = 8'h00;
            endcase
        end
        if (rise) begin
            if (q.bs == B_ADDR || q.bs == B_PTR || q.bs == B_WDAT) begin
                n.sh = {q.sh[6:0], sda};
                n.bcnt = q.bcnt + 4'd1;
            end else if (q.bs == B_RDAT) begin
                n.bcnt = q.bcnt + 4'd1;
            end else if (q.bs == B_MACK) begin
                n.bs = B_IDLE;
            end
        end
        if (fall) begin
            unique case (q.bs)
                B_IDLE, B_MACK: ;
                B_ADDR: if (byte_done) begin
                    n.bs = B_IDLE;
                    if (q.sh[7:1] == {DEV_HI, q.adr_s1}) begin
                        n.bs = B_AACK;
                        n.sda_oe = 1'b1;
                        n.rw = q.sh[0];
                    end
                end
                B_PTR: if (byte_done) begin
                    n.ptr = q.sh;
                    n.sda_oe = 1'b1;
                    n.bs = B_PACK;
                end
                B_WDAT: if (byte_done) begin
                    n.sda_oe = 1'b1;
                    n.bs = B_WACK;
                    if (q.ptr[7:5] == RAM_SEL) begin
                        n.ram[q.ptr[4:0]] = q.sh;
                    end
                    case (q.ptr)
                        A_CFG: begin
                            n.r.cfg = q.sh;
                            if (q.sh[C_INIT]) begin
                                n.r = REGS_INIT;
                            end
                            if (q.sh[C_RSTPLS] && q.r.fdiv[F_RSTMODE]) begin
                                n.rcnt = 21'(RST_PULSE_CYC);
                            end
                        end
                        A_IST1: n.r.ist1 = q.r.ist1 & ~q.sh;
                        A_IST2: n.r.ist2 = q.r.ist2 & ~q.sh;
                        A_IMK1: n.r.imk1 = q.sh;
                        A_IMK2: n.r.imk2 = q.sh;
                        A_FDIV: n.r.fdiv = q.sh;
                        A_OSCFG: n.r.oscfg = q.sh;
                        default: ;
                    endcase
                end
                B_AACK: begin
                    n.sda_oe = 1'b0;
                    n.bcnt = 4'd0;
                    n.bs = B_PTR;
                    if (q.rw) begin
                        n.sh = rd;
                        n.sda_oe = ~rd[7];
                        n.bs = B_RDAT;
                        rdres = q.ptr[7:5] == RAM_SEL && q.ptr[4:0] <= RES_TOP;
                    end
                end
                B_PACK: begin
                    n.sda_oe = 1'b0;
                    n.bcnt = 4'd0;
                    n.bs = B_WDAT;
                end
                B_WACK: begin
                    n.sda_oe = 1'b0;
                    n.bs = B_IDLE;
                end
                B_RDAT: begin
                    if (byte_done) begin
                        n.sda_oe = 1'b0;
                        n.bs = B_MACK;
                    end else begin
                        n.sh = {q.sh[6:0], 1'b0};
                        n.sda_oe = ~q.sh[6];
                    end
                end
            endcase
        end
        if (start) begin
            n.bs = B_ADDR;
            n.bcnt = 4'd0;
            n.sda_oe = 1'b0;
        end else if (stop) begin
            n.bs = B_IDLE;
            n.sda_oe = 1'b0;
        end
        if (!run) begin
            n.dwell = '0;
        end else if (q.dwell >= dlim) begin
            n.dwell = '0;
            n.strobe = 1'b1;
            n.item = (q.item == LAST_ITEM) ? 4'd0 : q.item + 4'd1;
            if (q.item == 4'd0) begin
                idx = R_TEMP;
            end else if (q.item <= 4'd7) begin
                idx = 5'(ch);
            end
            n.ram[idx] = MEAS_DATA;
            if (q.item == 4'd0) begin
                n.os_hot = $signed(MEAS_DATA) >= $signed(q.ram[L_TOS]);
                if ($signed(MEAS_DATA) >= $signed(q.ram[L_THOT])) begin
                    n.r.ist2[S2_THOT] = 1'b1;
                end
            end else if (q.item <= 4'd7) begin
                if (MEAS_DATA > q.ram[5'(L_IN + {ch, 1'b0})] ||
                    MEAS_DATA < q.ram[5'(L_IN + {ch, 1'b1})]) begin
                    n.r.ist1[ch] = 1'b1;
                end
            end else if (MEAS_DATA > q.ram[5'(L_FAN + {4'd0, q.item[0]})]) begin
                n.r.ist2[S2_FAN + int'(q.item[0])] = 1'b1;
            end
        end else begin
            n.dwell = q.dwell + 25'd1;
        end
        if (rdres) begin
            n.dwell = '0;
        end
        if (q.intr_s[1]) begin
            n.r.ist2[S2_INTR] = 1'b1;
        end
        if (q.rcnt != '0 && n.rcnt == q.rcnt) begin
            n.rcnt = q.rcnt - 21'd1;
        end
        n.lowcnt = q.rstn_s[1] ? 3'd0 :
            (q.lowcnt == 3'(EXT_RST_CYC - 1)) ? q.lowcnt : q.lowcnt + 3'd1;
        if (!q.rstn_s[1] && q.lowcnt == 3'(EXT_RST_CYC - 1)) begin
            n.r = REGS_INIT;
            n.bs = B_IDLE;
            n.sda_oe = 1'b0;
            n.item = 4'd0;
            n.dwell = '0;
            n.rcnt = '0;
            n.os_hot = 1'b0;
        end
        n.irq_oe = n.r.cfg[C_INTEN] & ~n.r.cfg[C_INTCLR] &
            (|(n.r.ist1 & ~n.r.imk1) | |(n.r.ist2 & ~n.r.imk2));
        n.irq_o = n.r.cfg[C_INTSRC];
        // reset or overtemp held off by clear
        n.rst_oe = ~n.r.cfg[C_INTCLR] & (n.r.fdiv[F_RSTMODE] ? n.rcnt != '0 :
            n.r.fdiv[F_OSMODE] & n.os_hot);
        n.intr_oe = n.r.cfg[C_CICLR];
        n.gp_lvl = n.r.cfg[C_GP_LVL];
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            q <= '0;
            q.r <= REGS_INIT;
        end else begin
            q <= n;
        end
    end

    assign SDA_O = q.lvl0;
    assign SDA_OE = q.sda_oe;
    assign IRQ_O = q.irq_o;
    assign IRQ_OE = q.irq_oe;
    assign RESET_OR_OVERTEMP_OUTPUT_O = q.lvl0;
    assign RESET_OR_OVERTEMP_OUTPUT_OE = q.rst_oe;
    assign CHASSIS_INTRUSION_PIN_O = q.lvl0;
    assign CHASSIS_INTRUSION_PIN_OE = q.intr_oe;
    assign GENERAL_PURPOSE_OUTPUT = q.gp_lvl;
    assign MEAS_SEL = q.item;
    assign MEAS_STROBE = q.strobe;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    sequence s_addr_byte;
        byte_done && q.bs == B_ADDR && !start && !stop && q.rstn_s[1];
    endsequence
    sequence s_held_low;
        !q.rstn_s[1] [*7];
    endsequence

    addr_match_a: assert property (
        s_addr_byte ##0 q.sh[7:1] == {DEV_HI, q.adr_s1} |=> q.sda_oe && q.bs == B_AACK)
        else $error("matching address not acknowledged");
    addr_ignore_a: assert property (
        s_addr_byte ##0 q.sh[7:1] != {DEV_HI, q.adr_s1} |=> !q.sda_oe && q.bs == B_IDLE)
        else $error("foreign address acknowledged");
    init_clear_a: assert property (
        byte_done && q.bs == B_WDAT && q.ptr == A_CFG && q.sh[C_INIT] && !start && !stop
        |=> q.r == REGS_INIT) else $error("soft init did not restore registers");
    init_ram_a: assert property (
        byte_done && q.bs == B_WDAT && q.ptr == A_CFG && !start && !stop
        |=> q.strobe || q.ram == $past(q.ram)) else $error("soft init touched value memory");
    ext_reset_a: assert property (
        s_held_low |=> q.r == REGS_INIT && q.bs == B_IDLE) else $error("external reset ignored");
    clear_quiet_a: assert property (
        q.r.cfg[C_INTCLR] |-> !q.rst_oe && !q.irq_oe) else $error("outputs driven while cleared");
    halt_loop_a: assert property (
        !run |=> !q.strobe [*2]) else $error("monitoring ran while stopped");
    pulse_len_a: assert property (
        $rose(q.rcnt != '0) |-> q.rcnt == 21'(RST_PULSE_CYC) ##1 q.rcnt == $past(q.rcnt) - 21'd1
        || q.rcnt == '0) else $error("reset pulse length wrong");
    loop_order_a: assert property (
        q.strobe && !$past(!q.rstn_s[1]) |-> q.item ==
        (($past(q.item) == LAST_ITEM) ? 4'd0 : $past(q.item) + 4'd1))
        else $error("item order broken");
    read_restart_a: assert property (
        fall && q.bs == B_AACK && q.rw && q.ptr[7:5] == RAM_SEL && q.ptr[4:0] <= RES_TOP
        && !start && !stop && q.rstn_s[1] |=> q.dwell == '0) else $error("result read no restart");
    ptr_hold_a: assert property (
        !(byte_done && q.bs == B_PTR) |=> q.ptr == $past(q.ptr)) else $error("pointer changed");
endmodule // hwm_top
`default_nettype wire

// file: rtl/hwm_pkg.sv
// hwm_pkg: register map, bit fields, reset values and timing of the hardware monitor
package hwm_pkg;
    // register pointer map
    localparam logic [7:0] A_CFG = 8'h00;
    localparam logic [7:0] A_IST1 = 8'h01;
    localparam logic [7:0] A_IST2 = 8'h02;
    localparam logic [7:0] A_IMK1 = 8'h03;
    localparam logic [7:0] A_IMK2 = 8'h04;
    localparam logic [7:0] A_FDIV = 8'h05;
    localparam logic [7:0] A_OSCFG = 8'h06;
    localparam logic [2:0] RAM_SEL = 3'h1;
    // value memory layout, index within the 32-byte window
    localparam logic [4:0] RES_TOP = 5'h09;
    localparam logic [4:0] R_TEMP = 5'h07;
    localparam logic [4:0] L_IN = 5'h0a;
    localparam logic [4:0] L_THOT = 5'h18;
    localparam logic [4:0] L_TOS = 5'h1a;
    localparam logic [4:0] L_FAN = 5'h1c;
    // control, mode and status bit positions; bus address and loop constants
    localparam int C_START = 0;
    localparam int C_INTEN = 1;
    localparam int C_INTSRC = 2;
    localparam int C_INTCLR = 3;
    localparam int C_RSTPLS = 4;
    localparam int C_CICLR = 5;
    localparam int C_GP_LVL = 6;
    localparam int C_INIT = 7;
    localparam int F_OSMODE = 6;
    localparam int F_RSTMODE = 7;
    localparam int O_RES12 = 3;
    localparam int S2_THOT = 0;
    localparam int S2_FAN = 2;
    localparam int S2_INTR = 4;
    localparam logic [3:0] DEV_HI = 4'h5;
    localparam logic [3:0] LAST_ITEM = 4'h9;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // timing
    localparam int CLK_NS = 8;
    localparam int EXT_RST_NS = 50;
    localparam int EXT_RST_CYC = (EXT_RST_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_PULSE_MS = 10;
    localparam int RST_PULSE_DEF = RST_PULSE_MS * 1000000 / CLK_NS;
    localparam int PASS_MS = 1000;
    localparam int ITEM_CYC_DEF = PASS_MS * 1000000 / CLK_NS / 10;

    typedef enum logic [3:0] {B_IDLE, B_ADDR, B_AACK, B_PTR, B_PACK, B_WDAT, B_WACK, B_RDAT,
        B_MACK} hwm_bus_t;

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] ist1;
        logic [7:0] ist2;
        logic [7:0] imk1;
        logic [7:0] imk2;
        logic [7:0] fdiv;
        logic [7:0] oscfg;
    } hwm_regs_t;

    localparam hwm_regs_t REGS_INIT = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h01};

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [1:0] intr_s;
        logic [1:0] rstn_s;
        logic [2:0] adr_s0;
        logic [2:0] adr_s1;
        logic scl_p;
        logic sda_p;
        hwm_bus_t bs;
        logic [3:0] bcnt;
        logic [7:0] sh;
        logic rw;
        logic [7:0] ptr;
        logic sda_oe;
        hwm_regs_t r;
        logic [31:0][7:0] ram;
        logic [3:0] item;
        logic [24:0] dwell;
        logic strobe;
        logic [20:0] rcnt;
        logic [2:0] lowcnt;
        logic os_hot;
        logic lvl0;
        logic irq_o;
        logic irq_oe;
        logic rst_oe;
        logic intr_oe;
        logic gp_lvl;
    } hwm_state_t;
endpackage

// file: sim/hwm_host.sv
// hwm_host: two-wire bus master model that drives the serial clock and pulls the data line
`timescale 1ns/1ns
`default_nettype none
module hwm_host (
    // clock
    input wire logic clk,
    // bus lines
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    // clock stands high and data is released between frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic start();
        tick(5);
        sda_pull = 1'b0;
        tick(5);
        scl = 1'b1;
        tick(10);
        sda_pull = 1'b1;
        tick(10);
        scl = 1'b0;
    endtask
    task automatic stop();
        tick(5);
        sda_pull = 1'b1;
        tick(5);
        scl = 1'b1;
        tick(10);
        sda_pull = 1'b0;
        tick(10);
    endtask
    // data changes only while the clock is low, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        tick(5);
        sda_pull = ~b;
        tick(5);
        scl = 1'b1;
        tick(5);
        s = sda;
        tick(5);
        scl = 1'b0;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    // not-acknowledge after the single read byte
    task automatic rd_byte(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(1'b1, s);
    endtask
endmodule // hwm_host
`default_nettype wire

// file: sim/test_hw_monitor_bus_control.sv
// test_hw_monitor_bus_control: bus access, control outputs and monitoring loop checks
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_hw_monitor_bus_control;
    import hwm_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ext_rst_n = 1'b1;
    logic intr_in = 1'b0;
    logic [7:0] meas_data = 8'h00;
    logic [2:0] pins = 3'h5;
    logic scl, host_pull, sda_oe, sda_w, rst_oe, intr_oe, gp_out, irq_o, irq_oe, strobe;
    logic sda_o, ros_o, intr_o;
    logic [3:0] sel;
    logic [3:0] seen[$];
    logic [7:0] pwr [0:6] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h01};
    int bad_count = 0;
    int comparisons = 0;
    int plen = 0;
    int gap = 0;
    int scnt = 0;
    int n;
    always #4 clk_sys = ~clk_sys;
    // open-drain data line with pull-up
    assign sda_w = ~(host_pull | sda_oe);
    always @(posedge clk_sys) begin
        #1;
        meas_data <= 8'h30 + {4'h0, sel};
        if (strobe) seen.push_back(sel);
        if (rst_oe) plen <= plen + 1;
        // spacing of conversion strobes in cycles
        scnt <= strobe ? 1 : scnt + 1;
        if (strobe) gap <= scnt;
    end
    hwm_top #(.RST_PULSE_CYC(50), .ITEM_CYC(20)) dut_u (
        .CLK_SYS(clk_sys), .RST(rst), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
        .SDA_OE(sda_oe), .BUS_ADDRESS_PINS(pins), .EXTERNAL_RESET_INPUT_N(ext_rst_n),
        .IRQ_O(irq_o), .IRQ_OE(irq_oe), .RESET_OR_OVERTEMP_OUTPUT_O(ros_o),
        .RESET_OR_OVERTEMP_OUTPUT_OE(rst_oe), .CHASSIS_INTRUSION_PIN_I(intr_in),
        .CHASSIS_INTRUSION_PIN_O(intr_o), .CHASSIS_INTRUSION_PIN_OE(intr_oe),
        .GENERAL_PURPOSE_OUTPUT(gp_out), .MEAS_SEL(sel), .MEAS_STROBE(strobe),
        .MEAS_DATA(meas_data)
    );
    hwm_host host_u (.clk(clk_sys), .sda(sda_w), .scl(scl), .sda_pull(host_pull));
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic results();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // address byte, pointer byte, data byte; first acknowledge compared
    task automatic wreg(input logic [2:0] ap, input logic [7:0] a, d, input logic ex);
        logic ack;
        host_u.start();
        host_u.wr_byte({DEV_HI, ap, 1'b0}, ack);
        `CHK(ack, ex)
        host_u.wr_byte(a, ack);
        host_u.wr_byte(d, ack);
        host_u.stop();
    endtask
    // read with the pointer as it stands
    task automatic rnow(input logic [7:0] e);
        logic ack;
        logic [7:0] d;
        host_u.start();
        host_u.wr_byte({DEV_HI, pins, 1'b1}, ack);
        host_u.rd_byte(d);
        host_u.stop();
        `CHK(d, e)
    endtask
    // pointer write, then restart and read
    task automatic rchk(input logic [7:0] a, e);
        logic ack;
        logic [7:0] d;
        host_u.start();
        host_u.wr_byte({DEV_HI, pins, 1'b0}, ack);
        host_u.wr_byte(a, ack);
        host_u.start();
        host_u.wr_byte({DEV_HI, pins, 1'b1}, ack);
        host_u.rd_byte(d);
        host_u.stop();
        `CHK(d, e)
    endtask
    initial begin
        wait_cyc(80000);
        bad_count++;
        results();
    end
    initial begin
        wait_cyc(4);
        rst = 1'b0;
        wait_cyc(4);
        `CHK({irq_oe, rst_oe}, 2'b00)
        for (int i = 0; i < 7; i++) rchk(i[7:0], pwr[i]);
        wreg(pins, 8'h10, 8'hff, 1'b1);
        rchk(8'h10, 8'h00);
        // foreign address: no acknowledge, frame ignored
        wreg(3'h2, A_CFG, 8'h40, 1'b0);
        `CHK(gp_out, 1'b0)
        wreg(pins, 8'h2a, 8'h5a, 1'b1);
        rchk(8'h2a, 8'h5a);
        rnow(8'h5a);
        rnow(8'h5a);
        wreg(pins, A_CFG, 8'h60, 1'b1);
        `CHK({gp_out, intr_oe}, 2'b11)
        `CHK({intr_o, ros_o, sda_o}, 3'b000)
        // pulse request outside reset mode does nothing
        plen = 0;
        wreg(pins, A_CFG, 8'h10, 1'b1);
        wait_cyc(60);
        `CHK(plen, 0)
        wreg(pins, A_FDIV, 8'h94, 1'b1);
        plen = 0;
        wreg(pins, A_CFG, 8'h10, 1'b1);
        wait_cyc(60);
        `CHK(plen inside {[49:51]}, 1'b1)
        wreg(pins, A_CFG, 8'h80, 1'b1);
        rchk(A_CFG, 8'h08);
        rchk(A_FDIV, 8'h14);
        rchk(8'h2a, 8'h5a);
        // run the loop for a full pass and more
        seen.delete();
        wreg(pins, A_CFG, 8'h01, 1'b1);
        n = 0;
        while (seen.size() < 12 && n < 2000) begin
            wait_cyc(1);
            n++;
        end
        `CHK(gap, 20)
        rchk(8'h28, 8'h38);
        wreg(pins, A_CFG, 8'h00, 1'b1);
        `CHK(seen[0], 4'h1)
        for (int i = 0; i < 11; i++) begin
            `CHK(seen[i+1], (seen[i] == 4'h9) ? 4'h0 : seen[i] + 4'h1)
        end
        n = seen.size();
        wait_cyc(200);
        `CHK(seen.size(), n)
        // read frames outlast the scaled item dwell
        for (int k = 0; k < 7; k++) rchk(8'h20 + k[7:0], 8'h31 + k[7:0]);
        rchk(8'h27, 8'h30);
        rchk(8'h28, 8'h38);
        rchk(8'h29, 8'h39);
        rchk(A_IST1, 8'h7e);
        rchk(A_IST2, 8'h0d);
        wreg(pins, A_CFG, 8'h02, 1'b1);
        `CHK({irq_oe, irq_o}, 2'b10)
        wreg(pins, A_CFG, 8'h06, 1'b1);
        `CHK({irq_oe, irq_o}, 2'b11)
        wreg(pins, A_CFG, 8'h0f, 1'b1);
        `CHK(irq_oe, 1'b0)
        n = seen.size();
        wait_cyc(200);
        `CHK(seen.size(), n)
        rchk(A_IST1, 8'h7e);
        // 12-bit mode doubles the dwell of every item
        wreg(pins, A_OSCFG, 8'h09, 1'b1);
        wreg(pins, A_CFG, 8'h01, 1'b1);
        wait_cyc(200);
        `CHK(gap, 40)
        wreg(pins, A_CFG, 8'h00, 1'b1);
        intr_in = 1'b1;
        wait_cyc(10);
        intr_in = 1'b0;
        rchk(A_IST2, 8'h1d);
        wreg(pins, A_CFG, 8'h40, 1'b1);
        ext_rst_n = 1'b0;
        wait_cyc(10);
        ext_rst_n = 1'b1;
        wait_cyc(10);
        `CHK(gp_out, 1'b0)
        rchk(A_CFG, 8'h08);
        results();
    end
endmodule // test_hw_monitor_bus_control
`undef CHK
`default_nettype wire
